// *** rtl/mode3_cfg_pkg.sv ***
package mode3_cfg_pkg;

  // Register offsets on the serial bus
  localparam logic [7:0] CFG1_OFFSET = 8'h2F;
  localparam logic [7:0] CFG2_OFFSET = 8'h30;

  // Reset values: return cfg 1, offset 0, sys code 01100 / aon code 0100, all enables 1
  localparam logic [7:0] CFG1_RESET = 8'h4C;
  localparam logic [7:0] CFG2_RESET = 8'h4F;

  // Field positions
  localparam int BTN_CFG_BIT = 6;
  localparam int SYS_OFFSET_BIT = 5;
  localparam int SYS_CODE_LSB = 0;
  localparam int AON_CODE_LSB = 4;

  // Target address; value is arbitrary
  localparam logic [6:0] TARGET_ADDR_DEFAULT = 7'h2A;

  // Mode settings
  localparam logic [1:0] MODE_ZERO = 2'h0;
  localparam logic [1:0] MODE_THREE = 2'h3;

  // Voltage maps in millivolts
  localparam logic [11:0] STEP_MV = 12'h019;
  localparam logic [11:0] SYS_BASE_MV = 12'h5DC;
  localparam logic [11:0] SYS_CAP_CODE = 12'h018;
  localparam logic [11:0] SYS_OFFSET_MV = 12'h4B0;
  localparam logic [11:0] AON_BASE_MV = 12'h6A4;
  localparam logic [11:0] AON_CAP_CODE = 12'h008;

  // Synchroniser reset value for {modePins[1:0], button, sda, scl}
  localparam logic [4:0] PIN_SYNC_RESET = 5'h07;

  typedef enum logic [3:0] {Idle, Addr, AddrAck, Ptr, PtrAck, Wr, WrAck, Rd, RdAck} i2cState_t;

  typedef struct packed {
    logic [11:0] sysMv;
    logic [11:0] aonMv;
    logic [3:0] enables;
  } regulatorCtl_t;

  typedef struct packed {
    i2cState_t st;
    logic [7:0] shift;
    logic [3:0] bitCnt;
    logic rw;
    logic nack;
    logic [7:0] ptr;
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic sclPrev;
    logic sdaPrev;
    logic btnPrev;
    logic returnHold;
    logic [1:0] lastSel;
    logic [1:0] activeMode;
    logic sdaOut;
    logic sdaOe;
    logic mode3Active;
    regulatorCtl_t ctl;
  } state_t;

endpackage

// *** rtl/mode3_regulator_config_regs.sv ***
`timescale 1ns/1ps
module mode3_regulator_config_regs #(
  parameter logic [6:0] TARGET_ADDR = mode3_cfg_pkg::TARGET_ADDR_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic powerButtonPin,
  input wire logic [1:0] modeSelectPins,
  input wire logic pinModeSelectEnable,
  input wire logic [1:0] modeSelectRegBits,
  output logic [1:0] activeMode,
  output logic mode3Active,
  output logic coreBuckEnable,
  output logic sysBuckEnable,
  output logic aonRegulatorEnable,
  output logic sysRegulatorEnable,
  output logic [11:0] sysBuckMillivolts,
  output logic [11:0] aonRegulatorMillivolts
);

  if (TARGET_ADDR == 7'h00) begin : gBadAddr
    $error("target address 0 is the general call address");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers

  logic rstMeta_q;
  logic rstLocalN;
  logic [4:0] pinLvl;
  logic sclLvl;
  logic sdaLvl;
  logic btnLvl;
  logic [1:0] modePinLvl;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstLocalN <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstLocalN <= rstMeta_q;
    end
  end

  pin_sync #(
    .W(5),
    .RESET_VAL(mode3_cfg_pkg::PIN_SYNC_RESET)
  ) uPinSync (
    .clk(clk_sys),
    .rstN(rstLocalN),
    .pinIn({modeSelectPins, powerButtonPin, sdaIn, sclIn}),
    .level(pinLvl)
  );

  assign sclLvl = pinLvl[0];
  assign sdaLvl = pinLvl[1];
  assign btnLvl = pinLvl[2];
  assign modePinLvl = pinLvl[4:3];

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [11:0] codeToMv(input logic [11:0] code, input logic [11:0] base,
                                           input logic [11:0] cap);
    logic [11:0] c;
    c = (code > cap) ? cap : code;
    return 12'(base + 12'(mode3_cfg_pkg::STEP_MV * c));
  endfunction

  function automatic logic [7:0] regRead(input logic [7:0] ptr, input logic [7:0] cfg1,
                                         input logic [7:0] cfg2);
    if (ptr == mode3_cfg_pkg::CFG1_OFFSET) begin
      return cfg1;
    end else if (ptr == mode3_cfg_pkg::CFG2_OFFSET) begin
      return cfg2;
    end else begin
      return 8'h00;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  mode3_cfg_pkg::state_t s_q;
  mode3_cfg_pkg::state_t s_d;
  logic sclRise;
  logic sclFall;
  logic busStart;
  logic busStop;
  logic btnFall;
  logic [1:0] selMode;
  logic [7:0] rdByte;

  always_comb begin
    s_d = s_q;
    sclRise = sclLvl & ~s_q.sclPrev;
    sclFall = ~sclLvl & s_q.sclPrev;
    busStart = sclLvl & s_q.sclPrev & s_q.sdaPrev & ~sdaLvl;
    busStop = sclLvl & s_q.sclPrev & ~s_q.sdaPrev & sdaLvl;
    btnFall = ~btnLvl & s_q.btnPrev;
    rdByte = regRead(s_q.ptr, s_q.cfg1, s_q.cfg2);
    s_d.sclPrev = sclLvl;
    s_d.sdaPrev = sdaLvl;
    s_d.btnPrev = btnLvl;
    // Serial register access
    if (busStart) begin
      s_d.st = mode3_cfg_pkg::Addr;
      s_d.bitCnt = 4'h0;
      s_d.sdaOe = 1'b0;
    end else if (busStop) begin
      s_d.st = mode3_cfg_pkg::Idle;
      s_d.sdaOe = 1'b0;
    end else begin
      case (s_q.st)
        mode3_cfg_pkg::Addr, mode3_cfg_pkg::Ptr, mode3_cfg_pkg::Wr: begin
          if (sclRise && s_q.bitCnt < 4'h8) begin
            s_d.shift = {s_q.shift[6:0], sdaLvl};
            s_d.bitCnt = 4'(s_q.bitCnt + 4'h1);
          end else if (sclFall && s_q.bitCnt == 4'h8) begin
            s_d.sdaOe = 1'b1;
            if (s_q.st == mode3_cfg_pkg::Addr) begin
              if (s_q.shift[7:1] == TARGET_ADDR) begin
                s_d.rw = s_q.shift[0];
                s_d.st = mode3_cfg_pkg::AddrAck;
              end else begin
                s_d.sdaOe = 1'b0;
                s_d.st = mode3_cfg_pkg::Idle;
              end
            end else if (s_q.st == mode3_cfg_pkg::Ptr) begin
              s_d.ptr = s_q.shift;
              s_d.st = mode3_cfg_pkg::PtrAck;
            end else begin
              if (s_q.ptr == mode3_cfg_pkg::CFG1_OFFSET) begin
                s_d.cfg1 = s_q.shift;
              end else if (s_q.ptr == mode3_cfg_pkg::CFG2_OFFSET) begin
                s_d.cfg2 = s_q.shift;
              end
              s_d.ptr = 8'(s_q.ptr + 8'h01);
              s_d.st = mode3_cfg_pkg::WrAck;
            end
          end
        end
        mode3_cfg_pkg::AddrAck: begin
          if (sclFall) begin
            s_d.bitCnt = s_q.rw ? 4'h1 : 4'h0;
            s_d.shift = rdByte;
            s_d.sdaOe = s_q.rw & ~rdByte[7];
            s_d.nack = 1'b0;
            s_d.st = s_q.rw ? mode3_cfg_pkg::Rd : mode3_cfg_pkg::Ptr;
          end
        end
        mode3_cfg_pkg::PtrAck, mode3_cfg_pkg::WrAck: begin
          if (sclFall) begin
            s_d.sdaOe = 1'b0;
            s_d.bitCnt = 4'h0;
            s_d.st = mode3_cfg_pkg::Wr;
          end
        end
        mode3_cfg_pkg::Rd: begin
          if (sclFall) begin
            if (s_q.bitCnt == 4'h8) begin
              s_d.sdaOe = 1'b0;
              s_d.st = mode3_cfg_pkg::RdAck;
            end else begin
              s_d.shift = {s_q.shift[6:0], 1'b0};
              s_d.sdaOe = ~s_q.shift[6];
              s_d.bitCnt = 4'(s_q.bitCnt + 4'h1);
            end
          end
        end
        mode3_cfg_pkg::RdAck: begin
          if (sclRise) begin
            s_d.nack = sdaLvl;
          end else if (sclFall) begin
            if (s_q.nack) begin
              s_d.st = mode3_cfg_pkg::Idle;
            end else begin
              s_d.ptr = 8'(s_q.ptr + 8'h01);
              s_d.shift = regRead(8'(s_q.ptr + 8'h01), s_q.cfg1, s_q.cfg2);
              s_d.sdaOe = ~s_d.shift[7];
              s_d.bitCnt = 4'h1;
              s_d.st = mode3_cfg_pkg::Rd;
            end
          end
        end
        default: begin
          s_d.sdaOe = 1'b0;
        end
      endcase
    end
    // Mode selection
    selMode = pinModeSelectEnable ? modePinLvl : modeSelectRegBits;
    s_d.lastSel = selMode;
    if (selMode != s_q.lastSel) begin
      s_d.returnHold = 1'b0;
    end
    if (btnFall && s_q.activeMode == mode3_cfg_pkg::MODE_THREE && !s_q.cfg1[mode3_cfg_pkg::BTN_CFG_BIT]) begin
      s_d.returnHold = 1'b1;
    end
    s_d.activeMode = s_d.returnHold ? mode3_cfg_pkg::MODE_ZERO : selMode;
    s_d.mode3Active = (s_d.activeMode == mode3_cfg_pkg::MODE_THREE);
    // Regulator controls, only while mode 3 is active
    if (s_d.mode3Active) begin
      s_d.ctl.enables = s_q.cfg2[3:0];
      s_d.ctl.sysMv = 12'(codeToMv({7'h00, s_q.cfg1[mode3_cfg_pkg::SYS_CODE_LSB +: 5]}, mode3_cfg_pkg::SYS_BASE_MV,
                                   mode3_cfg_pkg::SYS_CAP_CODE)
                          + (s_q.cfg1[mode3_cfg_pkg::SYS_OFFSET_BIT] ? mode3_cfg_pkg::SYS_OFFSET_MV : 12'h000));
      s_d.ctl.aonMv = codeToMv({8'h00, s_q.cfg2[mode3_cfg_pkg::AON_CODE_LSB +: 4]},
                               mode3_cfg_pkg::AON_BASE_MV, mode3_cfg_pkg::AON_CAP_CODE);
    end else begin
      s_d.ctl = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstLocalN) begin
    if (!rstLocalN) begin
      s_q <= '0;
      s_q.st <= mode3_cfg_pkg::Idle;
      s_q.cfg1 <= mode3_cfg_pkg::CFG1_RESET;
      s_q.cfg2 <= mode3_cfg_pkg::CFG2_RESET;
      s_q.sclPrev <= 1'b1;
      s_q.sdaPrev <= 1'b1;
      s_q.btnPrev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign sdaOut = s_q.sdaOut;
  assign sdaOe = s_q.sdaOe;
  assign activeMode = s_q.activeMode;
  assign mode3Active = s_q.mode3Active;
  assign coreBuckEnable = s_q.ctl.enables[3];
  assign sysBuckEnable = s_q.ctl.enables[2];
  assign aonRegulatorEnable = s_q.ctl.enables[1];
  assign sysRegulatorEnable = s_q.ctl.enables[0];
  assign sysBuckMillivolts = s_q.ctl.sysMv;
  assign aonRegulatorMillivolts = s_q.ctl.aonMv;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic [11:0] expSysMv;
  logic [11:0] expAonMv;
  assign expSysMv = 12'(((s_q.cfg1[4:0] > 5'h18) ? 12'h834 : 12'(12'h5DC + 12'h019 * {7'h00, s_q.cfg1[4:0]}))
                        + (s_q.cfg1[5] ? 12'h4B0 : 12'h000));
  assign expAonMv = (s_q.cfg2[7:4] > 4'h8) ? 12'h76C : 12'(12'h6A4 + 12'h019 * {8'h00, s_q.cfg2[7:4]});

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstLocalN);

  btn_return_a: assert property (btnFall && s_q.activeMode == 2'h3 && !s_q.cfg1[6] |=> s_q.activeMode == 2'h0
                                 ##1 (s_q.activeMode == 2'h0 || s_q.lastSel != $past(s_q.lastSel)))
    else $error("button edge did not return to mode 0");
  mode0_stay_a: assert property (btnFall && s_q.activeMode == 2'h0 && selMode == s_q.lastSel
                                 |=> s_q.activeMode == 2'h0)
    else $error("mode 0 changed on button edge");
  btn_ignore_a: assert property (btnFall && s_q.cfg1[6] && selMode == s_q.lastSel |=> $stable(s_q.activeMode))
    else $error("mode changed with button cfg set");
  cfg_reset_a: assert property ($rose(rstLocalN) |-> s_q.cfg1 == 8'h4C && s_q.cfg2 == 8'h4F)
    else $error("configuration reset values wrong");
  sys_offset_a: assert property (s_q.mode3Active && $past(s_q.mode3Active) && s_q.cfg1[5]
                                 |=> !s_q.mode3Active || s_q.ctl.sysMv >= 12'hA8C)
    else $error("system buck offset missing");
  sys_volt_a: assert property (s_q.mode3Active |=> !s_q.mode3Active || s_q.ctl.sysMv == $past(expSysMv))
    else $error("system buck voltage wrong");
  aon_volt_a: assert property (s_q.mode3Active |=> !s_q.mode3Active || s_q.ctl.aonMv == $past(expAonMv))
    else $error("always-on voltage wrong");
  core_en_a: assert property (s_q.mode3Active |-> coreBuckEnable == $past(s_q.cfg2[3]))
    else $error("core buck enable wrong");
  sys_en_a: assert property (s_q.mode3Active |-> sysBuckEnable == $past(s_q.cfg2[2]))
    else $error("system buck enable wrong");
  aon_en_a: assert property (s_q.mode3Active |-> aonRegulatorEnable == $past(s_q.cfg2[1]))
    else $error("always-on enable wrong");
  sysreg_en_a: assert property (s_q.mode3Active |-> sysRegulatorEnable == $past(s_q.cfg2[0]))
    else $error("system regulator enable wrong");
  pin_select_a: assert property (pinModeSelectEnable && !btnFall && selMode != s_q.lastSel
                                 |=> s_q.activeMode == $past(modePinLvl))
    else $error("mode did not follow pins");
  gated_ctl_a: assert property (!s_q.mode3Active |-> s_q.ctl == '0)
    else $error("regulator controls driven outside mode 3");

  return_seen_c: cover property (btnFall && s_q.activeMode == 2'h3 && !s_q.cfg1[6] ##1 s_q.activeMode == 2'h0);
  cfg_write_c: cover property (s_q.st == mode3_cfg_pkg::WrAck && s_q.ptr == 8'h31);
  read_done_c: cover property (s_q.st == mode3_cfg_pkg::RdAck ##1 s_q.st == mode3_cfg_pkg::Idle);
  mode3_on_c: cover property ($rose(s_q.mode3Active));

endmodule

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] level
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  if (W < 1) begin : gBadWidth
    $error("pin_sync width must be at least 1");
  end

  // A change counts once the second and third stages agree
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
      level <= RESET_VAL;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

// *** verification/i2c_host_model.sv ***
`timescale 1ns/1ps
module i2c_host_model #(
  parameter int HALF = 8,
  parameter logic [6:0] ADDR = mode3_cfg_pkg::TARGET_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic sdaLevel,
  output logic scl,
  output logic sdaPull
);
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic halfWait();
    repeat (HALF) @(posedge clk);
  endtask
  // Start or repeated start: SDA falls while SCL is high
  task automatic startCond();
    sdaPull <= 1'b0;
    halfWait();
    scl <= 1'b1;
    halfWait();
    sdaPull <= 1'b1;
    halfWait();
    scl <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic stopCond();
    sdaPull <= 1'b1;
    halfWait();
    scl <= 1'b1;
    halfWait();
    sdaPull <= 1'b0;
    halfWait();
  endtask
  // SDA changes only while SCL is low, two clocks clear of the falling edge
  task automatic bitXfer(input logic b, output logic r);
    sdaPull <= ~b;
    halfWait();
    scl <= 1'b1;
    halfWait();
    r = sdaLevel;
    scl <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic byteXfer(input logic [7:0] d, input logic ackBit, output logic [7:0] r, output logic ackSeen);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bitXfer(d[i], r[i]);
    end
    bitXfer(ackBit, a);
    ackSeen = ~a;
  endtask
  task automatic writeRegs(input logic [6:0] addr, input logic [7:0] ptr, input logic [7:0] d0,
                           input logic [7:0] d1, output logic ok);
    logic [7:0] r;
    logic a0;
    logic a1;
    logic a2;
    logic a3;
    startCond();
    byteXfer({addr, 1'b0}, 1'b1, r, a0);
    byteXfer(ptr, 1'b1, r, a1);
    byteXfer(d0, 1'b1, r, a2);
    byteXfer(d1, 1'b1, r, a3);
    stopCond();
    ok = a0 & a1 & a2 & a3;
  endtask
  // Pointer write, repeated start, two bytes read: first acknowledged, last refused
  task automatic readRegs(input logic [7:0] ptr, output logic [7:0] r0, output logic [7:0] r1);
    logic [7:0] r;
    logic a;
    startCond();
    byteXfer({ADDR, 1'b0}, 1'b1, r, a);
    byteXfer(ptr, 1'b1, r, a);
    startCond();
    byteXfer({ADDR, 1'b1}, 1'b1, r, a);
    byteXfer(8'hFF, 1'b0, r0, a);
    byteXfer(8'hFF, 1'b1, r1, a);
    stopCond();
  endtask
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin errCount++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb_top;
  logic clk_sys;
  logic rst_n;
  logic powerButtonPin;
  logic [1:0] modeSelectPins;
  logic pinModeSelectEnable;
  logic [1:0] modeSelectRegBits;
  logic scl;
  logic sdaPull;
  logic sdaOut;
  logic sdaOe;
  logic sdaLevel;
  logic [1:0] activeMode;
  logic mode3Active;
  logic [3:0] enables;
  logic [11:0] sysMv;
  logic [11:0] aonMv;
  logic [7:0] r0;
  logic [7:0] r1;
  logic ok;
  int errCount;
  int nTests;
  // Columns: cfg1, cfg2, system buck mV, always-on mV
  logic [39:0] rows [5] = '{
    {8'h40, 8'h00, 12'h5DC, 12'h6A4},
    {8'h58, 8'h8A, 12'h834, 12'h76C},
    {8'h5F, 8'hF5, 12'h834, 12'h76C},
    {8'h78, 8'h3F, 12'hCE4, 12'h6EF},
    {8'hE1, 8'h14, 12'hAA5, 12'h6BD}
  };
  // Open-drain SDA with pull-up
  assign sdaLevel = ~((sdaOe & ~sdaOut) | sdaPull);
  mode3_regulator_config_regs dut_u (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sclIn(scl),
    .sdaIn(sdaLevel),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .powerButtonPin(powerButtonPin),
    .modeSelectPins(modeSelectPins),
    .pinModeSelectEnable(pinModeSelectEnable),
    .modeSelectRegBits(modeSelectRegBits),
    .activeMode(activeMode),
    .mode3Active(mode3Active),
    .coreBuckEnable(enables[3]),
    .sysBuckEnable(enables[2]),
    .aonRegulatorEnable(enables[1]),
    .sysRegulatorEnable(enables[0]),
    .sysBuckMillivolts(sysMv),
    .aonRegulatorMillivolts(aonMv)
  );
  i2c_host_model hostU (
    .clk(clk_sys),
    .sdaLevel(sdaLevel),
    .scl(scl),
    .sdaPull(sdaPull)
  );
  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic press();
    powerButtonPin <= 1'b0;
    repeat (10) @(posedge clk_sys);
    powerButtonPin <= 1'b1;
    repeat (10) @(posedge clk_sys);
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    errCount++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    powerButtonPin = 1'b1;
    modeSelectPins = 2'h0;
    pinModeSelectEnable = 1'b0;
    modeSelectRegBits = 2'h3;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    // Reset values seen at the regulator controls and read back
    `CHK(sysMv, 12'h708)
    `CHK(aonMv, 12'h708)
    `CHK(enables, 4'hF)
    `CHK(sdaOut, 1'b0)
    hostU.readRegs(8'h2F, r0, r1);
    `CHK(r0, 8'h4C)
    `CHK(r1, 8'h4F)
    hostU.readRegs(8'h30, r0, r1);
    `CHK(r0, 8'h4F)
    `CHK(r1, 8'h00)
    // Wrong target address is not acknowledged and writes nothing
    hostU.writeRegs(7'h2B, 8'h2F, 8'h00, 8'h00, ok);
    `CHK(ok, 1'b0)
    hostU.readRegs(8'h2F, r0, r1);
    `CHK(r0, 8'h4C)
    // Table of field settings in mode 3
    foreach (rows[i]) begin
      hostU.writeRegs(mode3_cfg_pkg::TARGET_ADDR_DEFAULT, 8'h2F, rows[i][39:32], rows[i][31:24], ok);
      `CHK(ok, 1'b1)
      hostU.readRegs(8'h2F, r0, r1);
      `CHK(r0, rows[i][39:32])
      `CHK(r1, rows[i][31:24])
      `CHK(sysMv, rows[i][23:12])
      `CHK(aonMv, rows[i][11:0])
      `CHK(enables, rows[i][27:24])
      `CHK(mode3Active, 1'b1)
    end
    // Outside mode 3 the stored settings have no effect
    modeSelectRegBits <= 2'h1;
    repeat (6) @(posedge clk_sys);
    `CHK(activeMode, 2'h1)
    `CHK({enables, sysMv, aonMv}, 28'h0)
    // Pin selection overrides the register bits
    pinModeSelectEnable <= 1'b1;
    modeSelectPins <= 2'h3;
    modeSelectRegBits <= 2'h0;
    repeat (8) @(posedge clk_sys);
    `CHK(activeMode, 2'h3)
    modeSelectPins <= 2'h2;
    repeat (8) @(posedge clk_sys);
    `CHK(activeMode, 2'h2)
    pinModeSelectEnable <= 1'b0;
    modeSelectRegBits <= 2'h3;
    repeat (8) @(posedge clk_sys);
    `CHK(activeMode, 2'h3)
    // Button keeps mode 3 with return disabled, returns to mode 0 with return enabled, and leaves mode 0 unchanged
    press();
    `CHK(activeMode, 2'h3)
    hostU.writeRegs(mode3_cfg_pkg::TARGET_ADDR_DEFAULT, 8'h2F, 8'h0C, 8'h4F, ok);
    repeat (4) @(posedge clk_sys);
    `CHK(sysMv, 12'h708)
    press();
    `CHK(activeMode, 2'h0)
    `CHK(enables, 4'h0)
    modeSelectRegBits <= 2'h0;
    repeat (8) @(posedge clk_sys);
    press();
    `CHK(activeMode, 2'h0)
    // Reset in mid-run brings back the reset values
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK({activeMode, mode3Active, enables, sdaOe}, 8'h00)
    rst_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    hostU.readRegs(8'h2F, r0, r1);
    `CHK(r0, 8'h4C)
    `CHK(r1, 8'h4F)
    final_report();
  end
endmodule
